// File: hw/sop_pkg.sv
package sop_pkg;
  localparam int          CLK_MHZ      = 100;
  localparam int          RES_W        = 16;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          CNT_W        = 12;
  localparam int          ACQ_TIME_NS  = 1000;
  localparam int          CONV_TIME_NS = 3000;
  localparam logic [11:0] ACQ_CYC      = 12'((ACQ_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] CONV_CYC     = 12'((CONV_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [1:0]  SCLK_DIV     = 2'h2;
  localparam logic [4:0]  FRAME_BITS   = 5'h10;
  localparam int          SER_DATA_BIT = 8;
  localparam int          SER_CLK_BIT  = 9;
  localparam int          SER_SYNC_BIT = 10;
  localparam int          SER_ERR_BIT  = 11;
  localparam int          HIZ_LO_BIT   = 12;
  localparam int          HIZ_HI_BIT   = 15;
  localparam logic [11:0] PIN_RST      = 12'h016;
  localparam logic [15:0] RESULT_RST   = 16'h0000;
  localparam logic [15:0] OE_OFF       = 16'hFFFF;

  typedef enum logic [1:0] {CV_ACQ, CV_WAIT, CV_CONV} sop_conv_e;

  typedef struct packed {
    logic conv_reset;
    logic port_select;
    logic clock_source_select;
    logic clock_edge_invert;
    logic frame_sync_polarity;
    logic output_coding_select;
    logic power_down_in;
    logic convert_start_n;
    logic read_mode_or_chain_in;
    logic cs_n;
    logic rd_n;
    logic sclk;
  } sop_pins_s;

  typedef struct packed {
    logic [15:0] data;
    logic [15:0] oe_n;
  } sop_bus_s;

  // High selects offset binary, low flips the sign bit for two's complement
  function automatic logic [15:0] sop_code(input logic [15:0] raw, input logic ob);
    sop_code = {raw[15] ^ ~ob, raw[14:0]};
  endfunction
endpackage

// File: hw/sop_top.sv
`timescale 1ns/10ps
module sop_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clr,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [W-1:0] mem_nxt [D];
  logic [AW:0]  wr_r, wr_nxt, rd_r, rd_nxt;
  logic         push, pop;

  assign in_ready  = (wr_r[AW] == rd_r[AW]) || (wr_r[AW-1:0] != rd_r[AW-1:0]);
  assign out_valid = wr_r != rd_r;
  assign out_data  = mem_r[rd_r[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_nxt = mem_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    if (clr) begin
      wr_nxt = '0;
      rd_nxt = '0;
    end else begin
      if (push) begin
        mem_nxt[wr_r[AW-1:0]] = in_data;
        wr_nxt                = wr_r + (AW+1)'(1);
      end
      if (pop) begin
        rd_nxt = rd_r + (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      for (int i = 0; i < D; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      mem_r <= mem_nxt;
    end
  end
endmodule // sop_fifo

module sop_top
  import sop_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  input  wire logic        CONV_RESET,
  input  wire logic        PORT_SELECT,
  input  wire logic        CLOCK_SOURCE_SELECT,
  input  wire logic        CLOCK_EDGE_INVERT,
  input  wire logic        FRAME_SYNC_POLARITY,
  input  wire logic        OUTPUT_CODING_SELECT,
  input  wire logic        POWER_DOWN_IN,
  input  wire logic        CONVERT_START_N,
  input  wire logic        READ_MODE_OR_CHAIN_IN,
  input  wire logic        CS_N,
  input  wire logic        RD_N,
  input  wire logic        SCLK_IN,
  input  wire logic [15:0] CORE_RESULT,
  output logic             CORE_HOLD,
  output logic             BUSY,
  output logic      [15:0] DATA_OUT,
  output logic      [15:0] DATA_OE_N
);
  logic [11:0] s1_r, s2_r;
  sop_pins_s   p;
  logic        sclk_d_r, cnv_d_r, rd_d_r;
  sop_conv_e   st_r, st_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic        push, in_ready, f_valid, pop;
  logic [15:0] f_data;
  logic [15:0] sh_r, sh_nxt;
  logic        full_r, full_nxt, mact_r, mact_nxt, err_r, err_nxt, sclko_r, sclko_nxt;
  logic [4:0]  bits_r, bits_nxt;
  logic [1:0]  ph_r, ph_nxt, div_r, div_nxt;
  sop_bus_s    bus_r, bus_nxt;
  logic        ser, mst, slv, sel, tick, sedge, sreading, acq_end;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s1_r <= PIN_RST;
      s2_r <= PIN_RST;
    end else begin
      s1_r <= {CONV_RESET, PORT_SELECT, CLOCK_SOURCE_SELECT, CLOCK_EDGE_INVERT, FRAME_SYNC_POLARITY,
               OUTPUT_CODING_SELECT, POWER_DOWN_IN, CONVERT_START_N, READ_MODE_OR_CHAIN_IN, CS_N, RD_N,
               SCLK_IN};
      s2_r <= s1_r;
    end
  end

  assign p   = sop_pins_s'(s2_r);
  assign ser = p.port_select;
  assign mst = ser && !p.clock_source_select;
  assign slv = ser && p.clock_source_select;
  assign sel = !p.cs_n && !p.rd_n;

  assign acq_end = (st_r == CV_ACQ) && (cnt_r == ACQ_CYC - 12'h001);

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    push    = 1'b0;
    unique case (st_r)
      CV_ACQ: begin
        if (!acq_end) begin
          cnt_nxt = cnt_r + 12'h001;
        // no new start in power down
        end else if (!p.power_down_in && in_ready) begin
          cnt_nxt = '0;
          st_nxt  = p.convert_start_n ? CV_WAIT : CV_CONV;
        end
      end
      CV_WAIT: begin
        if (cnv_d_r && !p.convert_start_n && !p.power_down_in && in_ready) begin
          st_nxt = CV_CONV;
        end
      end
      CV_CONV: begin
        cnt_nxt = cnt_r + 12'h001;
        if (cnt_r == CONV_CYC - 12'h001) begin
          push    = 1'b1;
          cnt_nxt = '0;
          st_nxt  = CV_ACQ;
        end
      end
    endcase
    if (p.conv_reset) begin
      st_nxt  = CV_ACQ;
      cnt_nxt = '0;
      push    = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r     <= CV_ACQ;
      cnt_r    <= '0;
      sclk_d_r <= 1'b0;
      cnv_d_r  <= 1'b1;
      rd_d_r   <= 1'b1;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      sclk_d_r <= p.sclk;
      cnv_d_r  <= p.convert_start_n;
      rd_d_r   <= p.rd_n;
    end
  end

  assign CORE_HOLD = st_r == CV_CONV;
  assign BUSY      = (st_r == CV_CONV) || f_valid;
  assign pop       = f_valid && !full_r;

  sop_fifo #(.W(RES_W), .D(FIFO_DEPTH)) u_fifo (
    .clk       (REF_CLK),
    .rst_n     (RESETN),
    .clr       (p.conv_reset),
    .in_valid  (push),
    .in_ready  (in_ready),
    .in_data   (sop_code(CORE_RESULT, p.output_coding_select)),
    .out_valid (f_valid),
    .out_ready (!full_r),
    .out_data  (f_data)
  );

  assign tick     = div_r == SCLK_DIV - 2'h1;
  assign sedge    = !p.cs_n && (p.clock_edge_invert ? (sclk_d_r && !p.sclk) : (!sclk_d_r && p.sclk));
  assign sreading = slv && full_r && (bits_r != 5'h00);

  always_comb begin
    sh_nxt    = sh_r;
    full_nxt  = full_r;
    mact_nxt  = mact_r;
    bits_nxt  = bits_r;
    ph_nxt    = ph_r;
    err_nxt   = 1'b0;
    div_nxt   = tick ? 2'h0 : div_r + 2'h1;
    if (pop) begin
      sh_nxt   = f_data;
      full_nxt = 1'b1;
      bits_nxt = '0;
    end else if (!ser) begin
      if (!p.cs_n && p.rd_n && !rd_d_r) begin
        full_nxt = 1'b0;
      end
    end else if (slv) begin
      if (push && sreading) begin
        full_nxt = 1'b0;
        bits_nxt = '0;
        err_nxt  = 1'b1;
      end else if (sedge && full_r) begin
        sh_nxt   = {sh_r[14:0], p.read_mode_or_chain_in};
        bits_nxt = bits_r + 5'h01;
        if (bits_r == FRAME_BITS - 5'h01) begin
          full_nxt = 1'b0;
        end
      end
    end else if (!mact_r) begin
      if (sel && full_r && (p.read_mode_or_chain_in || st_r != CV_CONV)) begin
        mact_nxt = 1'b1;
        ph_nxt   = '0;
        bits_nxt = '0;
      end
    end else if (tick) begin
      ph_nxt = ph_r + 2'h1;
      if (ph_r == 2'h3) begin
        sh_nxt   = {sh_r[14:0], 1'b0};
        bits_nxt = bits_r + 5'h01;
        if (bits_r == FRAME_BITS - 5'h01) begin
          mact_nxt = 1'b0;
          full_nxt = 1'b0;
        end
      end
    end
    sclko_nxt = mact_nxt && (ph_nxt == 2'h1);
    if (p.conv_reset) begin
      full_nxt = 1'b0;
      mact_nxt = 1'b0;
      bits_nxt = '0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sh_r    <= RESULT_RST;
      full_r  <= 1'b0;
      mact_r  <= 1'b0;
      bits_r  <= '0;
      ph_r    <= '0;
      div_r   <= '0;
      err_r   <= 1'b0;
      sclko_r <= 1'b0;
    end else begin
      sh_r    <= sh_nxt;
      full_r  <= full_nxt;
      mact_r  <= mact_nxt;
      bits_r  <= bits_nxt;
      ph_r    <= ph_nxt;
      div_r   <= div_nxt;
      err_r   <= err_nxt;
      sclko_r <= sclko_nxt;
    end
  end

  always_comb begin
    bus_nxt.data = '0;
    bus_nxt.oe_n = OE_OFF;
    if (!ser) begin
      // full parallel word incl. bits 8-11
      bus_nxt.data = sh_r;
      bus_nxt.oe_n = sel ? ~OE_OFF : OE_OFF;
    end else begin
      bus_nxt.data[SER_DATA_BIT] = sh_r[15];
      bus_nxt.data[SER_CLK_BIT]  = sclko_r ^ p.clock_edge_invert;
      bus_nxt.data[SER_SYNC_BIT] = mact_r ^ p.frame_sync_polarity;
      bus_nxt.data[SER_ERR_BIT]  = err_r;
      if (sel) begin
        bus_nxt.oe_n[SER_DATA_BIT] = 1'b0;
        bus_nxt.oe_n[SER_CLK_BIT]  = !mst;
        bus_nxt.oe_n[SER_SYNC_BIT] = !mst;
        bus_nxt.oe_n[SER_ERR_BIT]  = !slv;
      end
      bus_nxt.oe_n[HIZ_HI_BIT:HIZ_LO_BIT] = OE_OFF[HIZ_HI_BIT:HIZ_LO_BIT];
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bus_r <= '{data: RESULT_RST, oe_n: OE_OFF};
    end else begin
      bus_r <= bus_nxt;
    end
  end

  assign DATA_OUT  = bus_r.data;
  assign DATA_OE_N = bus_r.oe_n;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  sequence s_acq_done;
    acq_end && !p.power_down_in && in_ready && !p.conv_reset;
  endsequence
  sequence s_clk_high;
    mact_r && ph_r == 2'h1;
  endsequence

  a_par_upper_float: assert property (ser |=> &DATA_OE_N[15:12])
    else $error("upper parallel bits driven in serial mode");
  a_oe_needs_sel: assert property (!sel |=> DATA_OE_N == OE_OFF)
    else $error("outputs enabled without select and read");
  a_busy_latch: assert property (push |=> BUSY && f_valid)
    else $error("busy dropped before result latched");
  a_err_on_drop: assert property (push && sreading && !p.conv_reset |=> err_r ##1 !err_r)
    else $error("incomplete read flag not a single pulse");
  a_reset_abort: assert property (p.conv_reset |=> st_r == CV_ACQ && !BUSY && !err_r)
    else $error("reset did not abort conversion");
  a_pd_no_start: assert property (p.power_down_in && st_r != CV_CONV |=> st_r != CV_CONV)
    else $error("conversion started in power down");
  a_wait_falling: assert property (s_acq_done ##0 p.convert_start_n |=> st_r == CV_WAIT)
    else $error("convert start high did not wait for falling edge");
  a_load_msb: assert property (pop && !p.conv_reset |=> sh_r == $past(f_data))
    else $error("shift register not loaded from result");
  a_mst_stable: assert property (s_clk_high |=> $stable(sh_r[15]))
    else $error("master data changed across clock edge");
  a_sync_level: assert property (mst ##0 s_clk_high |=> DATA_OUT[SER_SYNC_BIT] == !$past(p.frame_sync_polarity))
    else $error("frame sync level wrong");
  a_cs_gate: assert property (slv && p.cs_n && !pop && !push && !p.conv_reset |=> $stable(bits_r))
    else $error("serial clock counted without chip select");
endmodule // sop_top

// File: verification/sop_host_model.sv
`timescale 1ns/10ps
module sop_host_model (
  input  wire logic inv,
  input  wire logic sdo,
  output logic      sclk
);
  initial sclk = 1'b0;

  task automatic clock_bits(input int n, output logic [15:0] w);
    w = 16'h0000;
    sclk = inv;
    // Eighth-cycle offset keeps every edge 1.25 ns clear of the sampling clock edges
    #126.25;
    for (int i = 0; i < n; i++) begin
      w = {w[14:0], sdo};
      sclk = ~sclk;
      #62.5;
      sclk = ~sclk;
      #62.5;
    end
  endtask
endmodule // sop_host_model

// File: verification/sop_tb.sv
`timescale 1ns/10ps
module testbench;
  import sop_pkg::*;
  logic        clk, rst_n, crst, psel, csel, einv, spol, ocs, pd, cnv_n, rdm, cs_n, rd_n, sclk, busy, hold;
  logic [15:0] core, dout, oe_n, w;
  int          n_mismatch, n_checks, n;

  sop_top u_dut (
    .REF_CLK(clk), .RESETN(rst_n), .CONV_RESET(crst), .PORT_SELECT(psel),
    .CLOCK_SOURCE_SELECT(csel), .CLOCK_EDGE_INVERT(einv), .FRAME_SYNC_POLARITY(spol),
    .OUTPUT_CODING_SELECT(ocs), .POWER_DOWN_IN(pd), .CONVERT_START_N(cnv_n),
    .READ_MODE_OR_CHAIN_IN(rdm), .CS_N(cs_n), .RD_N(rd_n), .SCLK_IN(sclk), .CORE_RESULT(core),
    .CORE_HOLD(hold), .BUSY(busy), .DATA_OUT(dout), .DATA_OE_N(oe_n)
  );

  // Undriven data pin shows the inverse of its last value
  sop_host_model u_host (.inv(einv), .sdo(dout[SER_DATA_BIT] ^ oe_n[SER_DATA_BIT]), .sclk(sclk));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_busy(input logic v, input int lim);
    n = 0;
    while (busy !== v) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        check({15'h0, busy}, {15'h0, v});
        test_done();
      end
    end
  endtask

  task automatic quiet(input int lim);
    logic hit;
    hit = 1'b0;
    repeat (lim) begin
      @(negedge clk);
      hit |= busy !== 1'b0;
    end
    check({15'h0, hit}, 16'h0000);
  endtask

  task automatic start_conv(input logic [15:0] raw);
    repeat (120) @(posedge clk);
    core  <= raw;
    cnv_n <= 1'b0;
    repeat (4) @(posedge clk);
    cnv_n <= 1'b1;
  endtask

  task automatic convert(input logic [15:0] raw);
    start_conv(raw);
    wait_busy(1'b1, 200);
    wait_busy(1'b0, 400);
    check(16'(n >= int'(CONV_CYC)), 16'h0001);
  endtask

  // Read strobe rises before chip select so a parallel read is consumed
  task automatic select(input logic v);
    @(posedge clk);
    rd_n <= v;
    if (!v) cs_n <= 1'b0;
    repeat (5) @(negedge clk);
    if (v) begin
      @(posedge clk);
      cs_n <= 1'b1;
      repeat (5) @(negedge clk);
    end
  endtask

  task automatic conv_reset();
    @(posedge clk);
    crst <= 1'b1;
    repeat (4) @(posedge clk);
    crst <= 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic s_abort();
    @(negedge clk);
    check({15'h0, busy}, 16'h0000);
    check(oe_n, OE_OFF);
    @(posedge clk);
    cnv_n <= 1'b0;
    conv_reset();
    wait_busy(1'b1, 130);
    conv_reset();
    check({15'h0, busy}, 16'h0000);
    @(posedge clk);
    cnv_n <= 1'b1;
    quiet(200);
  endtask

  task automatic s_parallel();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      ocs <= i[0];
      convert(16'h3C5A);
      @(posedge clk);
      cs_n <= 1'b0;
      repeat (5) @(negedge clk);
      check(oe_n, OE_OFF);
      select(1'b0);
      check(oe_n, 16'h0000);
      check(dout, i ? 16'h3C5A : 16'hBC5A);
      select(1'b1);
      check(oe_n, OE_OFF);
    end
  endtask

  task automatic s_slave();
    @(posedge clk);
    psel <= 1'b1;
    csel <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      einv <= i[0];
      convert(16'hA5C3 ^ 16'(i));
      u_host.clock_bits(4, w);
      select(1'b0);
      check(oe_n & 16'hF300, 16'hF200);
      u_host.clock_bits(16, w);
      check(w, 16'hA5C3 ^ 16'(i));
      select(1'b1);
    end
  endtask

  task automatic s_error();
    logic hit;
    @(posedge clk);
    einv <= 1'b0;
    convert(16'h0F0F);
    select(1'b0);
    u_host.clock_bits(5, w);
    check(w, 16'h0001);
    start_conv(16'h7E81);
    hit = 1'b0;
    repeat (500) begin
      @(negedge clk);
      hit |= dout[SER_ERR_BIT] === 1'b1;
    end
    check({15'h0, hit}, 16'h0001);
    u_host.clock_bits(16, w);
    check(w, 16'h7E81);
    select(1'b1);
  endtask

  task automatic s_master();
    logic p, bad;
    int   k;
    @(posedge clk);
    csel <= 1'b0;
    rdm  <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      spol <= i[0];
      select(1'b0);
      check({8'h00, oe_n[15:8]}, 16'h00F8);
      start_conv(16'hC3A6 ^ 16'(i));
      p = dout[SER_CLK_BIT];
      k = 0;
      bad = 1'b0;
      repeat (700) begin
        @(negedge clk);
        if (k < 16 && dout[SER_CLK_BIT] === 1'b1 && p === 1'b0) begin
          w = {w[14:0], dout[SER_DATA_BIT]};
          k++;
          bad |= dout[SER_SYNC_BIT] !== ~i[0];
        end
        bad |= dout[SER_CLK_BIT] === 1'b0 && p === 1'b1 && dout[SER_DATA_BIT] !== w[0];
        p = dout[SER_CLK_BIT];
      end
      check(w, 16'hC3A6 ^ 16'(i));
      check({15'h0, bad}, 16'h0000);
      select(1'b1);
    end
    // Read mode low: a held word waits until the conversion ends
    @(posedge clk);
    rdm <= 1'b0;
    convert(16'h1234);
    start_conv(16'h4321);
    select(1'b0);
    bad = 1'b0;
    repeat (280) begin
      @(negedge clk);
      bad |= dout[SER_SYNC_BIT] !== 1'b1;
    end
    check({15'h0, bad}, 16'h0000);
    wait_busy(1'b0, 400);
    select(1'b1);
  endtask

  task automatic s_power();
    start_conv(16'h5555);
    wait_busy(1'b1, 200);
    @(posedge clk);
    pd <= 1'b1;
    wait_busy(1'b0, 400);
    check(16'(n > 250), 16'h0001);
    start_conv(16'hAAAA);
    quiet(500);
    @(posedge clk);
    pd <= 1'b0;
  endtask

  task automatic s_fifo();
    logic p;
    int   k;
    conv_reset();
    @(posedge clk);
    psel  <= 1'b0;
    ocs   <= 1'b1;
    cnv_n <= 1'b0;
    p = 1'b0;
    k = 0;
    repeat (8000) begin
      @(negedge clk);
      if (hold === 1'b1 && p === 1'b0) k++;
      p = hold;
      @(posedge clk);
      core <= 16'(k);
    end
    cnv_n <= 1'b1;
    check(16'(k), 16'(FIFO_DEPTH + 1));
    for (int j = 1; j <= FIFO_DEPTH + 1; j++) begin
      select(1'b0);
      check(dout, 16'(j));
      select(1'b1);
    end
    check({15'h0, busy}, 16'h0000);
  endtask

  initial begin
    {rst_n, crst, psel, csel, einv, spol, pd, rdm} = '0;
    {ocs, cnv_n, cs_n, rd_n} = '1;
    core = 16'h0000;
    w = 16'h0000;
    n_mismatch = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    s_abort();
    s_parallel();
    s_slave();
    s_error();
    s_master();
    s_power();
    s_fifo();
    test_done();
  end
endmodule // testbench
